// ===== rtl/bir_pkg.sv
// board interrupt routing: shared constants, register offsets and encodings
// assumes a single 50 MHz clock domain and an 8-bit plain register port
package bir_pkg;

  // register port geometry
  localparam int ADDR_W = 32;
  localparam int DATA_W = 8;

  // register byte addresses
  localparam logic [31:0] LOCAL_STAT_ADDR = 32'he800_0002;
  localparam logic [31:0] EVT_STAT_ADDR = 32'he800_0004;
  localparam logic [31:0] EVT_MASK_ADDR = 32'he800_0005;
  localparam logic [31:0] EXC_PEND_LO_ADDR = 32'he800_0008;
  localparam logic [31:0] EXC_PEND_HI_ADDR = 32'he800_0009;
  localparam logic [31:0] EXC_EN_LO_ADDR = 32'he800_000a;
  localparam logic [31:0] EXC_EN_HI_ADDR = 32'he800_000b;
  localparam logic [31:0] VEC_BASE_ADDR = 32'he800_000c;

  // values after reset
  localparam logic [7:0] EVT_MASK_RST = 8'h00;
  localparam logic [15:0] EXC_EN_RST = 16'h0000;
  localparam logic [7:0] VEC_BASE_RST = 8'h00;

  // external interrupt input positions
  localparam int NUM_EXT = 11;
  localparam int NUM_LINES = 4;
  localparam int EXT_BP_A = 0;
  localparam int EXT_ENUM = 4;
  localparam int EXT_UNUSED = 5;
  localparam int EXT_TEMP = 6;
  localparam int EXT_FAN0 = 7;
  localparam int EXT_FAN1 = 8;
  localparam int EXT_PGOOD = 9;
  localparam int EXT_LOCAL = 10;

  // board event status bit positions
  localparam int NUM_EVT = 8;
  localparam int EVT_LINE_A = 0;
  localparam int EVT_ENUM = 4;
  localparam int EVT_TEMP = 5;
  localparam int EVT_FAN = 6;
  localparam int EVT_PGOOD = 7;

  // vector offset index encodings
  localparam int NUM_VEC = 16;
  localparam logic [3:0] VEC_CRIT_IN = 4'h0;
  localparam logic [3:0] VEC_MCHK = 4'h1;
  localparam logic [3:0] VEC_EXT_IN = 4'h4;
  localparam logic [3:0] VEC_PROGRAM = 4'h6;
  localparam logic [3:0] VEC_DEC = 4'ha;
  localparam logic [3:0] VEC_FIT = 4'hb;
  localparam logic [3:0] VEC_WDOG = 4'hc;
  localparam logic [3:0] VEC_DTLB = 4'hd;
  localparam logic [3:0] VEC_ITLB = 4'he;
  localparam logic [3:0] VEC_DEBUG = 4'hf;

  // types 0,1,4,6,10,11,12,15 can be masked; the rest always fire
  localparam logic [15:0] MASKABLE_TYPES = 16'h9c53;
  // types 0,1,12,15 use the critical save pair
  localparam logic [15:0] CRIT_TYPES = 16'h9003;

  // machine state bits dropped on entry (disables further entries of the class)
  localparam logic [31:0] MSV_CLEAR_NC = 32'h0000_8000;
  localparam logic [31:0] MSV_CLEAR_CR = 32'h0002_8000;

  // handler address layout: low nibble of the base byte on top, index times 16 at the bottom
  localparam int VEC_SHIFT = 4;
  localparam logic [19:0] HANDLER_GAP = 20'h00000;

  typedef enum logic [0:0] {BIR_IDLE, BIR_REQ} bir_state_t;

endpackage

// ===== rtl/bir_top.sv
// board interrupt routing: source-to-input map, local line status, exception
// pending/masking and interrupt entry context save for the embedded core
// assumes all inputs synchronous to clk; register port answers reads next cycle
`timescale 1ns/1ps

module bir_top import bir_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // interrupt sources, all active low
  input wire logic [3:0] bp_int_n,
  input wire logic enum_n,
  input wire logic temp_alarm_n,
  input wire logic fan0_alarm_n,
  input wire logic fan1_alarm_n,
  input wire logic power_good_int_n,
  input wire logic [NUM_LINES-1:0] local_pci_int_lines_n,
  // external interrupt inputs of the core, active high
  output logic [NUM_EXT-1:0] ext_int_inputs_q,
  // other exception events of the core, one-cycle pulses
  input wire logic [NUM_VEC-1:0] exc_events,
  // interrupt entry handshake with the core
  input wire logic [31:0] core_msv,
  input wire logic [31:0] core_next_addr,
  input wire logic core_int_ack,
  output logic core_int_req,
  output logic [3:0] core_int_vector_q,
  output logic core_int_critical_q,
  // context produced at entry
  output logic [31:0] handler_addr_q,
  output logic [31:0] new_msv_q,
  output logic [31:0] nc_save_addr_q,
  output logic [31:0] nc_save_msv_q,
  output logic [31:0] cr_save_addr_q,
  output logic [31:0] cr_save_msv_q,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata_q,
  // board interrupt
  output logic board_irq
);

  logic [NUM_EXT-1:0] ext_d;
  logic [NUM_LINES-1:0] local_pci_int_lines_level_q;
  logic [NUM_EVT-1:0] evt_raw, evt_prev_q, evt_rise, evt_stat_q, evt_mask_q, evt_clr;
  logic [NUM_VEC-1:0] exc_src, exc_pend_q, exc_en_q, exc_en_eff, exc_fire, exc_clr;
  logic [NUM_VEC-1:0] exc_sw_clr, exc_hw_clr;
  logic [7:0] vec_base_q;
  logic [3:0] sel_idx;
  logic sel_valid;
  logic ext_any;
  bir_state_t state_q;
  logic take;

  // source to input map, inverted to active high
  assign ext_d[EXT_BP_A +: 4] = ~bp_int_n;
  assign ext_d[EXT_ENUM] = ~enum_n;
  assign ext_d[EXT_UNUSED] = 1'b0;
  assign ext_d[EXT_TEMP] = ~temp_alarm_n;
  assign ext_d[EXT_FAN0] = ~fan0_alarm_n;
  assign ext_d[EXT_FAN1] = ~fan1_alarm_n;
  assign ext_d[EXT_PGOOD] = ~power_good_int_n;
  assign ext_d[EXT_LOCAL] = |(~local_pci_int_lines_n);

  // registered so the core sees glitch-free levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_int_inputs_q <= '0;
      local_pci_int_lines_level_q <= '0;
    end else begin
      ext_int_inputs_q <= ext_d;
      local_pci_int_lines_level_q <= ~local_pci_int_lines_n;
    end
  end

  // write and read decodes
  logic wr_evt_stat, wr_evt_mask, wr_pend_lo, wr_pend_hi, wr_en_lo, wr_en_hi, wr_vec;
  assign wr_evt_stat = reg_wr && (reg_addr == EVT_STAT_ADDR);
  assign wr_evt_mask = reg_wr && (reg_addr == EVT_MASK_ADDR);
  assign wr_pend_lo = reg_wr && (reg_addr == EXC_PEND_LO_ADDR);
  assign wr_pend_hi = reg_wr && (reg_addr == EXC_PEND_HI_ADDR);
  assign wr_en_lo = reg_wr && (reg_addr == EXC_EN_LO_ADDR);
  assign wr_en_hi = reg_wr && (reg_addr == EXC_EN_HI_ADDR);
  assign wr_vec = reg_wr && (reg_addr == VEC_BASE_ADDR);

  // read mux; a write to the local status address matches nothing above
  logic [DATA_W-1:0] rd_mux;
  assign rd_mux =
    (reg_addr == LOCAL_STAT_ADDR) ? {4'h0, local_pci_int_lines_level_q} :
    (reg_addr == EVT_STAT_ADDR) ? evt_stat_q :
    (reg_addr == EVT_MASK_ADDR) ? evt_mask_q :
    (reg_addr == EXC_PEND_LO_ADDR) ? exc_pend_q[7:0] :
    (reg_addr == EXC_PEND_HI_ADDR) ? exc_pend_q[15:8] :
    (reg_addr == EXC_EN_LO_ADDR) ? exc_en_q[7:0] :
    (reg_addr == EXC_EN_HI_ADDR) ? exc_en_q[15:8] :
    (reg_addr == VEC_BASE_ADDR) ? vec_base_q : 8'h00;

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // software-written controls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_mask_q <= EVT_MASK_RST;
      exc_en_q <= EXC_EN_RST;
      vec_base_q <= VEC_BASE_RST;
    end else begin
      if (wr_evt_mask) begin
        evt_mask_q <= reg_wdata;
      end
      if (wr_en_lo) begin
        exc_en_q[7:0] <= reg_wdata;
      end
      if (wr_en_hi) begin
        exc_en_q[15:8] <= reg_wdata;
      end
      if (wr_vec) begin
        vec_base_q <= reg_wdata;
      end
    end
  end

  // board events: rising edges of lines and alarms
  assign evt_raw = {ext_d[EXT_PGOOD], ext_d[EXT_FAN0] | ext_d[EXT_FAN1], ext_d[EXT_TEMP],
                    ext_d[EXT_ENUM], ~local_pci_int_lines_n};
  assign evt_rise = evt_raw & ~evt_prev_q;
  assign evt_clr = wr_evt_stat ? reg_wdata : 8'h00;
  assign board_irq = |(evt_stat_q & evt_mask_q);

  // exception sources; any routed external level feeds the external type
  assign ext_any = |ext_int_inputs_q;
  assign exc_src = exc_events | ({{(NUM_VEC-1){1'b0}}, ext_any} << VEC_EXT_IN);
  // non-maskable types count as always enabled
  assign exc_en_eff = exc_en_q | ~MASKABLE_TYPES;
  assign exc_fire = exc_pend_q & exc_en_eff;
  assign exc_sw_clr = {wr_pend_hi ? reg_wdata : 8'h00, wr_pend_lo ? reg_wdata : 8'h00};
  assign exc_hw_clr = take ? (16'h0001 << core_int_vector_q) : 16'h0000;
  assign exc_clr = exc_sw_clr | exc_hw_clr;

  // per-bit sticky flags; a set in the clearing cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < NUM_VEC; gi++) begin : g_flag
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          exc_pend_q[gi] <= 1'b0;
        end else if (exc_src[gi]) begin
          exc_pend_q[gi] <= 1'b1;
        end else if (exc_clr[gi]) begin
          exc_pend_q[gi] <= 1'b0;
        end
      end
      if (gi < NUM_EVT) begin : g_evt
        always_ff @(posedge clk or posedge rst) begin
          if (rst) begin
            evt_stat_q[gi] <= 1'b0;
            evt_prev_q[gi] <= 1'b0;
          end else begin
            evt_prev_q[gi] <= evt_raw[gi];
            if (evt_rise[gi]) begin
              evt_stat_q[gi] <= 1'b1;
            end else if (evt_clr[gi]) begin
              evt_stat_q[gi] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // priority: critical types first, then lowest index
  always_comb begin
    sel_idx = 4'h0;
    sel_valid = 1'b0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (exc_fire[i] && !CRIT_TYPES[i]) begin
        sel_idx = 4'(i);
        sel_valid = 1'b1;
      end
    end
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (exc_fire[i] && CRIT_TYPES[i]) begin
        sel_idx = 4'(i);
        sel_valid = 1'b1;
      end
    end
  end

  assign core_int_req = (state_q == BIR_REQ);
  assign take = core_int_req && core_int_ack;

  // entry sequencer; vector held steady while the core decides
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= BIR_IDLE;
      core_int_vector_q <= 4'h0;
      core_int_critical_q <= 1'b0;
    end else begin
      case (state_q)
        BIR_IDLE: begin
          if (sel_valid) begin
            state_q <= BIR_REQ;
            core_int_vector_q <= sel_idx;
            core_int_critical_q <= CRIT_TYPES[sel_idx];
          end
        end
        BIR_REQ: begin
          // withdraw when software cleared or masked the type meanwhile
          if (take || !exc_fire[core_int_vector_q]) begin
            state_q <= BIR_IDLE;
          end
        end
        default: begin
          state_q <= BIR_IDLE;
        end
      endcase
    end
  end

  // context save: separate pairs so a critical entry keeps the other intact
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      handler_addr_q <= 32'h0000_0000;
      new_msv_q <= 32'h0000_0000;
      nc_save_addr_q <= 32'h0000_0000;
      nc_save_msv_q <= 32'h0000_0000;
      cr_save_addr_q <= 32'h0000_0000;
      cr_save_msv_q <= 32'h0000_0000;
    end else if (take) begin
      handler_addr_q <= {vec_base_q, HANDLER_GAP, core_int_vector_q} << VEC_SHIFT;
      if (core_int_critical_q) begin
        cr_save_addr_q <= core_next_addr;
        cr_save_msv_q <= core_msv;
        new_msv_q <= core_msv & ~MSV_CLEAR_CR;
      end else begin
        nc_save_addr_q <= core_next_addr;
        nc_save_msv_q <= core_msv;
        new_msv_q <= core_msv & ~MSV_CLEAR_NC;
      end
    end
  end

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_local_or: assert property (
    ##1 ext_int_inputs_q[EXT_LOCAL] == |(~$past(local_pci_int_lines_n)))
    else $error("local interrupt input is not the OR of the four lines");

  a_status_read: assert property (
    reg_rd && reg_addr == LOCAL_STAT_ADDR |=> reg_rdata_q == {4'h0, $past(local_pci_int_lines_level_q)})
    else $error("local status read returned wrong value");

  a_route_map: assert property (
    ##1 ext_int_inputs_q[3:0] == ~$past(bp_int_n)
      && ext_int_inputs_q[EXT_PGOOD] == ~$past(power_good_int_n)
      && ext_int_inputs_q[EXT_FAN1] == ~$past(fan1_alarm_n))
    else $error("source routing to external inputs is wrong");

  a_unused_input: assert property (
    ##1 !ext_int_inputs_q[EXT_UNUSED] && ext_int_inputs_q[EXT_ENUM] == ~$past(enum_n))
    else $error("enumeration or unused input wrong");

  a_entry_save: assert property (
    take && !core_int_critical_q |=> nc_save_msv_q == $past(core_msv)
      && new_msv_q == ($past(core_msv) & ~MSV_CLEAR_NC) && !core_int_req)
    else $error("entry did not save or modify the state value");

  a_next_addr: assert property (
    take && core_int_critical_q |=> cr_save_addr_q == $past(core_next_addr))
    else $error("saved address is not the next instruction address");

  a_pair_split: assert property (
    take && core_int_critical_q |=> $stable(nc_save_addr_q) && $stable(nc_save_msv_q))
    else $error("critical entry overwrote the non-critical pair");

  a_vec_class: assert property (
    core_int_req |-> core_int_critical_q == CRIT_TYPES[core_int_vector_q])
    else $error("vector class does not match its index");

  a_nonmask_fire: assert property (
    state_q == BIR_IDLE && (exc_pend_q & ~MASKABLE_TYPES) != 16'h0000 |=> core_int_req)
    else $error("non-maskable pending type did not fire");

  a_masked_hold: assert property (
    state_q == BIR_IDLE && exc_fire == 16'h0000 |=> !core_int_req)
    else $error("masked exception produced a request");

  a_late_enable: assert property (
    state_q == BIR_IDLE && exc_pend_q[VEC_DEC] && $rose(exc_en_q[VEC_DEC]) |=> core_int_req)
    else $error("enabling a pending type did not fire it");

  a_status_level: assert property (
    reg_wr && reg_addr == LOCAL_STAT_ADDR |=> local_pci_int_lines_level_q == ~$past(local_pci_int_lines_n))
    else $error("local status does not follow line levels");

endmodule

// ===== testbench/bir_core_model.sv
// core stand-in: takes interrupt requests and acks after a chosen delay
// assumes one clock, async active-high reset, req held until ack sampled
`timescale 1ns/1ps
module bir_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request handshake
  input wire logic core_int_req,
  input wire logic [3:0] ack_delay,
  output logic core_int_ack,
  // context shown to the router
  output logic [31:0] core_msv,
  output logic [31:0] core_next_addr
);
  logic [3:0] wait_q;

  // address moves every cycle so a capture at the wrong edge shows up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_next_addr <= 32'h0000_1000;
    end else begin
      core_next_addr <= core_next_addr + 32'h4;
    end
  end

  // state value varies too, with both clear bits set early on
  assign core_msv = ~core_next_addr;

  // one-cycle ack, only while a request stands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 4'h0;
      core_int_ack <= 1'b0;
    end else if (core_int_ack || !core_int_req) begin
      wait_q <= 4'h0;
      core_int_ack <= 1'b0;
    end else if (wait_q >= ack_delay) begin
      core_int_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// ===== testbench/board_interrupt_routing_tb.sv
// self-checking bench for the board interrupt router
// assumes the core stand-in beside it; stimulus by nba at rising edges or 1 ns after them
`timescale 1ns/1ps
module board_interrupt_routing_tb import bir_pkg::*; ();
  logic clk, rst, enum_n, temp_alarm_n, fan0_alarm_n, fan1_alarm_n, power_good_int_n;
  logic [3:0] bp_int_n, core_int_vector_q, ack_delay;
  logic [NUM_LINES-1:0] local_pci_int_lines_n;
  logic [NUM_EXT-1:0] ext_int_inputs_q;
  logic [NUM_VEC-1:0] exc_events;
  logic [31:0] core_msv, core_next_addr, handler_addr_q, new_msv_q, reg_addr;
  logic [31:0] nc_save_addr_q, nc_save_msv_q, cr_save_addr_q, cr_save_msv_q;
  logic core_int_ack, core_int_req, core_int_critical_q, reg_wr, reg_rd, board_irq;
  logic [7:0] reg_wdata, reg_rdata_q, vb;
  int miscompares, checks, cycles;
  // rows: {active-low sources, expected core inputs, expected line status}
  localparam logic [27:0] ROWS [10] = '{{13'h1ffe, 11'h001, 4'h0},
    {13'h1ff7, 11'h008, 4'h0}, {13'h1fef, 11'h010, 4'h0}, {13'h1fdf, 11'h040, 4'h0},
    {13'h1fbf, 11'h080, 4'h0}, {13'h1f7f, 11'h100, 4'h0}, {13'h1eff, 11'h200, 4'h0},
    {13'h1dff, 11'h400, 4'h1}, {13'h0fff, 11'h400, 4'h8}, {13'h0000, 11'h7df, 4'hf}};
  localparam int LIST [7] = '{0, 1, 4, 11, 12, 14, 15};

  bir_top u_dut (.clk, .rst, .bp_int_n, .enum_n, .temp_alarm_n, .fan0_alarm_n,
    .fan1_alarm_n, .power_good_int_n, .local_pci_int_lines_n, .ext_int_inputs_q,
    .exc_events, .core_msv, .core_next_addr, .core_int_ack, .core_int_req,
    .core_int_vector_q, .core_int_critical_q, .handler_addr_q, .new_msv_q,
    .nc_save_addr_q, .nc_save_msv_q, .cr_save_addr_q, .cr_save_msv_q, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .board_irq);
  bir_core_model u_core (.clk, .rst, .core_int_req, .ack_delay, .core_int_ack,
    .core_msv, .core_next_addr);

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input string what, input logic [31:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk8(what, exp, reg_rdata_q);
  endtask
  // type 4 comes in through a one-cycle backplane pulse
  task automatic pulse(input int idx);
    @(posedge clk);
    if (idx == 4) bp_int_n[0] <= 1'b0;
    else exc_events[idx] <= 1'b1;
    @(posedge clk);
    bp_int_n <= 4'hf;
    exc_events <= '0;
  endtask
  // wait for the ack edge, then check the entry context against the core's
  task automatic serve(input int idx);
    logic crit;
    logic [31:0] ea, em, nca, ncm, cra, crm;
    int n;
    crit = CRIT_TYPES[idx];
    nca = nc_save_addr_q;
    ncm = nc_save_msv_q;
    cra = cr_save_addr_q;
    crm = cr_save_msv_q;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (core_int_ack !== 1'b1 && n < 40);
    ea = core_next_addr;
    em = core_msv;
    chk32("ack", 32'h1, 32'(core_int_ack));
    chk32("vector", 32'(idx), 32'(core_int_vector_q));
    chk32("critical", 32'(crit), 32'(core_int_critical_q));
    #1;
    chk32("handler", {vb, 20'h0, 4'(idx)} << VEC_SHIFT, handler_addr_q);
    chk32("new state", em & ~(crit ? MSV_CLEAR_CR : MSV_CLEAR_NC), new_msv_q);
    chk32("nc addr", crit ? nca : ea, nc_save_addr_q);
    chk32("nc state", crit ? ncm : em, nc_save_msv_q);
    chk32("cr addr", crit ? ea : cra, cr_save_addr_q);
    chk32("cr state", crit ? em : crm, cr_save_msv_q);
    chk32("req after ack", 32'h0, 32'(core_int_req));
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    {rst, bp_int_n, enum_n, temp_alarm_n, fan0_alarm_n, fan1_alarm_n} = 9'h1ff;
    {power_good_int_n, local_pci_int_lines_n, exc_events, ack_delay} = 25'h1f00000;
    {reg_addr, reg_wdata, reg_wr, reg_rd, vb} = 50'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      {local_pci_int_lines_n, power_good_int_n, fan1_alarm_n, fan0_alarm_n,
        temp_alarm_n, enum_n, bp_int_n} <= ROWS[i][27:15];
      repeat (2) @(posedge clk);
      #1;
      chk32("core inputs", 32'(ROWS[i][14:4]), 32'(ext_int_inputs_q));
      rd_chk("line status", LOCAL_STAT_ADDR, {4'h0, ROWS[i][3:0]});
    end
    $display("test source map done");
    // reset in mid-run with the event mask dirtied
    wr(EVT_MASK_ADDR, 8'h33);
    rst <= 1'b1;
    {local_pci_int_lines_n, power_good_int_n, fan1_alarm_n, fan0_alarm_n} <= 7'h7f;
    {temp_alarm_n, enum_n, bp_int_n} <= 6'h3f;
    repeat (2) @(posedge clk);
    chk32("inputs in reset", 32'h0, 32'(ext_int_inputs_q));
    rst <= 1'b0;
    rd_chk("mask reset", EVT_MASK_ADDR, EVT_MASK_RST);
    rd_chk("enable reset", EXC_EN_LO_ADDR, EXC_EN_RST[7:0]);
    rd_chk("base reset", VEC_BASE_ADDR, VEC_BASE_RST);
    $display("test reset done");
    // board event: raise, mask, unmask, clear
    // a set mask bit lets its status bit through to the board interrupt
    wr(EVT_MASK_ADDR, 8'hfd);
    local_pci_int_lines_n <= 4'hd;
    repeat (3) @(posedge clk);
    rd_chk("event status", EVT_STAT_ADDR, 8'h02);
    chk32("irq masked", 32'h0, 32'(board_irq));
    wr(EVT_MASK_ADDR, 8'hff);
    chk32("irq unmasked", 32'h1, 32'(board_irq));
    wr(EVT_STAT_ADDR, 8'h02);
    chk32("irq cleared", 32'h0, 32'(board_irq));
    local_pci_int_lines_n <= 4'hf;
    repeat (3) @(posedge clk);
    wr(EXC_PEND_LO_ADDR, 8'hff);
    $display("test board event done");
    // masked exception stays pending, fires once enabled
    vb = 8'h5a;
    wr(VEC_BASE_ADDR, vb);
    pulse(10);
    repeat (4) @(posedge clk);
    #1;
    chk32("req while masked", 32'h0, 32'(core_int_req));
    rd_chk("pending hi", EXC_PEND_HI_ADDR, 8'h04);
    wr(EXC_EN_HI_ADDR, 8'h04);
    serve(10);
    rd_chk("pending hi after", EXC_PEND_HI_ADDR, 8'h00);
    pulse(13);
    serve(13);
    $display("test pending done");
    // every listed vector type, prompt and slow acks
    wr(EXC_EN_LO_ADDR, 8'hff);
    wr(EXC_EN_HI_ADDR, 8'hff);
    for (int k = 0; k < 7; k++) begin
      ack_delay <= 4'(k % 2 * 5);
      pulse(LIST[k]);
      serve(LIST[k]);
    end
    $display("test vectors done");
    // request withdrawn when software clears the pending type before the ack
    ack_delay <= 4'hf;
    pulse(11);
    wr(EXC_PEND_HI_ADDR, 8'h08);
    chk32("req before withdraw", 32'h1, 32'(core_int_req));
    @(posedge clk);
    #1;
    chk32("req withdrawn", 32'h0, 32'(core_int_req));
    rd_chk("pending cleared", EXC_PEND_HI_ADDR, 8'h00);
    ack_delay <= 4'h0;
    $display("test withdraw done");
    // read-only status and an unmapped place
    wr(LOCAL_STAT_ADDR, 8'hff);
    rd_chk("status after write", LOCAL_STAT_ADDR, 8'h00);
    rd_chk("unmapped", 32'he800_0003, 8'h00);
    $display("test register access done");
    complete_run();
  end
endmodule
